/* design/arx_rx_framer.sv */
// Receive framing for one AIS channel and control of the DSC byte queue
//
// Overview of operation
// R1 - Link bit 1 pulses DSC queue clear
// R2 - Link bit 0 enables external packing
// R3 - Link bit 0 low: DSC channel feeds queue
// R4 - Raw: forward header and following bytes
// R5 - Raw stream stops while sleeping, settling or in DSC mode
// R6 - Raw: resync, stamp slot/sample per header
// R7 - Host decodes raw stream itself
// R8 - Raw bytes packed MSB first
// R9 - Host reverses decoded byte order
// R10 - Raw training bytes undecoded
// R11 - Raw state: Idle, then Receiving
// R12 - Burst: Receiving, NRZI, destuff, CRC
// R13 - Burst end: Idle or error, alert
// R14 - Too-long error past buffer size
// R15 - CRC mismatch error
// R16 - Overrun error, both buffers full
// R17 - Misaligned error, partial last byte
// R18 - Error: discard, alert, hunt again
// R19 - Good message into free buffer
// R20 - Turn: ready pulse, load, drain
// R21 - Ready waits for empty queue
// R22 - Burst training decodes alternating
// R23 - State reset wipes channel, settles
// R24 - Control bit 4 selects burst
// R25 - External data needs carrier, no squelch
// R26 - Host writes reserved link bits zero
// R27 - Distinct state code per outcome
`timescale 1ns/100ps
`default_nettype none

module arx_rx_framer
   import arx_pkg::*;
#(
   parameter int QUEUE_DEPTH = 32,
   parameter int SETTLE_CNT  = arx_pkg::SETTLE_CYCLES
)(
   // Clock and reset
   input  wire logic                    clk,
   input  wire logic                    sys_rst,
   // Decoded register writes
   input  wire logic                    reg_wr,
   input  wire logic [7:0]              reg_addr,
   input  wire logic [7:0]              reg_wdata,
   // Demodulated channel bits and timing
   input  wire logic                    demod_bit,
   input  wire logic                    demod_bit_valid,
   input  wire logic                    chan1_sleep,
   input  wire logic [15:0]             slot_count,
   input  wire logic [15:0]             sample_count,
   input  wire logic [15:0]             freq_err_in,
   input  wire logic [15:0]             rssi_in,
   // DSC sources
   input  wire logic [7:0]              dsc_main_byte,
   input  wire logic                    dsc_main_valid,
   input  wire logic                    ext_serial_in,
   input  wire logic                    ext_bit_valid,
   input  wire logic                    ext_carrier_detect,
   input  wire logic                    ext_squelch,
   // Queue reads
   input  wire logic                    chan1_byte_queue_pop,
   input  wire logic                    dsc_byte_queue_pop,
   output logic      [7:0]              chan1_byte_queue_head,
   output logic      [5:0]              chan1_byte_queue_fill,
   output logic      [7:0]              dsc_byte_queue_head,
   output logic      [5:0]              dsc_byte_queue_fill,
   // Channel results
   output var arx_pkg::arx_chstate_type chan1_state_reg,
   output logic      [15:0]             chan1_slot_stamp,
   output logic      [15:0]             chan1_sample_stamp,
   output logic      [15:0]             chan1_msg_length,
   output logic      [15:0]             chan1_freq_offset,
   output logic      [15:0]             chan1_signal_level,
   output logic                         chan1_state_alert_irq,
   output logic                         chan1_msg_ready_irq,
   output logic                         chan1_settling
);

   localparam int         PW     = $clog2(QUEUE_DEPTH);
   localparam logic [5:0] Q_FULL = 6'(QUEUE_DEPTH);

   // Register fields and write strobes
   logic            ctl_burst_reg;
   logic [1:0]      ctl_mode_reg;
   logic            link_en_reg;
   logic            wr_ctrl;
   logic            wr_link;
   logic            state_rst;
   logic            chan_clr;
   logic            dsc_clr;

   assign wr_ctrl   = reg_wr && (reg_addr == REG_CHAN1_CTRL);
   assign wr_link   = reg_wr && (reg_addr == REG_DSC_LINK_CONTROL);
   assign state_rst = wr_ctrl && reg_wdata[CTRL_STATE_RST_BIT];
   assign chan_clr  = wr_ctrl && reg_wdata[CTRL_FIFO_CLR_BIT];
   assign dsc_clr   = wr_link && reg_wdata[LINK_CLEAR_BIT];         // R1

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         ctl_burst_reg <= 1'b0;
         ctl_mode_reg  <= RESET_RX_MODE;
         link_en_reg   <= 1'b0;
      end
      else
      begin
         if (wr_ctrl)
         begin
            ctl_burst_reg <= reg_wdata[CTRL_BURST_BIT];              // R24
            ctl_mode_reg  <= reg_wdata[CTRL_MODE_LSB +: 2];
         end
         // Clear bit is a strobe, not stored
         if (wr_link)
         begin
            link_en_reg <= reg_wdata[LINK_ENABLE_BIT];              // R2
         end
      end
   end

   // Bit path idle while settling
   logic [15:0] settle_cnt;

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         settle_cnt     <= 16'h0000;
         chan1_settling <= 1'b0;
      end
      else if (state_rst)
      begin
         settle_cnt     <= 16'(SETTLE_CNT);                          // R23
         chan1_settling <= 1'b1;
      end
      else if (settle_cnt != 16'h0000)
      begin
         settle_cnt     <= settle_cnt - 16'h0001;
         chan1_settling <= (settle_cnt != 16'h0001);
      end
   end

   // NRZI decode, header search
   logic        bit_ok;
   logic        prev_raw;
   logic        d_bit;
   logic [31:0] dec_sr;
   logic [31:0] raw_sr;
   logic [31:0] dec_sr_nx;
   logic [31:0] raw_sr_nx;
   logic        hdr_hit;

   assign bit_ok    = demod_bit_valid && !chan1_sleep && !chan1_settling
                      && (ctl_mode_reg != RX_MODE_DSC);              // R5
   assign d_bit     = ~(demod_bit ^ prev_raw);
   assign dec_sr_nx = {dec_sr[30:0], d_bit};
   assign raw_sr_nx = {raw_sr[30:0], demod_bit};
   // First training bits may be corrupt
   assign hdr_hit   = bit_ok && (dec_sr_nx[7:0] == HDLC_FLAG)
                      && ((dec_sr_nx[23:8] == TRAIN_PAT_A)
                      || (dec_sr_nx[23:8] == TRAIN_PAT_B));          // R22

   always_ff @(posedge clk)
   begin
      if (sys_rst || state_rst)
      begin
         prev_raw <= 1'b0;
         dec_sr   <= 32'h00000000;
         raw_sr   <= 32'h00000000;
      end
      else if (bit_ok)
      begin
         prev_raw <= demod_bit;
         dec_sr   <= dec_sr_nx;
         raw_sr   <= raw_sr_nx;
      end
   end

   // Raw mode byte stream
   logic        raw_live;
   logic [2:0]  raw_cnt;
   logic [2:0]  emit_cnt;
   logic [31:0] emit_sr;
   logic        raw_emit;
   logic        raw_byte;

   assign raw_emit = !ctl_burst_reg && (emit_cnt != 3'h0);
   assign raw_byte = !ctl_burst_reg && raw_live && bit_ok && !hdr_hit
                     && (raw_cnt == 3'h7) && (emit_cnt == 3'h0);

   always_ff @(posedge clk)
   begin
      if (sys_rst || state_rst)
      begin
         raw_live <= 1'b0;
         raw_cnt  <= 3'h0;
         emit_cnt <= 3'h0;
         emit_sr  <= 32'h00000000;
      end
      else if (hdr_hit && !ctl_burst_reg)
      begin
         raw_live <= 1'b1;                                           // R6
         raw_cnt  <= 3'h0;
         emit_cnt <= HDR_BYTES[2:0];                                 // R4
         emit_sr  <= raw_sr_nx;                                      // R10
      end
      else
      begin
         if (emit_cnt != 3'h0)
         begin
            emit_cnt <= emit_cnt - 3'h1;
            emit_sr  <= {emit_sr[23:0], 8'h00};
         end
         if (bit_ok && raw_live)
         begin
            raw_cnt <= raw_cnt + 3'h1;
         end
      end
   end

   // Burst framer and message buffers
   arx_frame_type fr_state;
   logic [2:0]    ones;
   logic [10:0]   bitcnt;
   logic [7:0]    widx;
   logic [7:0]    byte_sr;
   logic [7:0]    dly;
   logic [15:0]   crc;
   logic          wr_ptr;
   logic [1:0]    buf_full;
   logic [7:0]    buf_mem [2][172];
   logic [7:0]    buf_len [2];
   logic [15:0]   stash_slot [2];
   logic [15:0]   stash_smp [2];
   logic [15:0]   stash_freq [2];
   logic [15:0]   stash_rssi [2];
   logic          rd_ptr;
   logic          drain_done;
   logic [7:0]    byte_nx;
   logic          crc_fb;
   logic [15:0]   crc_nx;

   assign byte_nx = {d_bit, byte_sr[7:1]};
   assign crc_fb  = crc[0] ^ dly[7];
   assign crc_nx  = {1'b0, crc[15:1]} ^ (crc_fb ? CRC_POLY : 16'h0000);

   always_ff @(posedge clk)
   begin
      if (sys_rst || state_rst)
      begin
         fr_state              <= FR_HUNT;
         chan1_state_reg       <= CH_IDLE;                           // R11
         chan1_state_alert_irq <= 1'b0;
         ones                  <= 3'h0;
         bitcnt                <= 11'h000;
         widx                  <= 8'h00;
         byte_sr               <= 8'h00;
         dly                   <= 8'h00;
         crc                   <= CRC_INIT;
         wr_ptr                <= 1'b0;
         buf_full              <= 2'b00;                             // R23
      end
      else
      begin
         chan1_state_alert_irq <= 1'b0;
         if (drain_done)
         begin
            buf_full[rd_ptr] <= 1'b0;
         end
         if (hdr_hit && !ctl_burst_reg)
         begin
            chan1_state_reg <= CH_RECEIVING;                         // R11
         end
         else if (bit_ok && ctl_burst_reg && (fr_state == FR_HUNT) && hdr_hit)
         begin
            if (buf_full == 2'b11)
            begin
               chan1_state_reg       <= CH_ERR_OVERRUN;              // R16
               chan1_state_alert_irq <= 1'b1;
            end
            else
            begin
               for (int k = 0; k < 4; k++)
               begin
                  buf_mem[wr_ptr][k] <= arx_rev8(dec_sr_nx[31 - 8 * k -: 8]);
               end
               chan1_state_reg    <= CH_RECEIVING;                   // R12
               fr_state           <= FR_FRAME;
               ones               <= 3'h0;
               bitcnt             <= 11'h000;
               widx               <= HDR_BYTES;
               crc                <= CRC_INIT;
               stash_slot[wr_ptr] <= slot_count;
               stash_smp[wr_ptr]  <= sample_count;
               stash_freq[wr_ptr] <= freq_err_in;
               stash_rssi[wr_ptr] <= rssi_in;
            end
         end
         else if (bit_ok && ctl_burst_reg && (fr_state == FR_FRAME))
         begin
            if (d_bit || (ones != STUFF_ONES))
            begin
               // Destuffed bit; CRC lags one byte
               byte_sr <= byte_nx;
               bitcnt  <= bitcnt + 11'h001;
               dly     <= {dly[6:0], d_bit};
               if (bitcnt >= 11'h008)
               begin
                  crc <= crc_nx;                                     // R12
               end
               if (bitcnt[2:0] == 3'h7 && widx != MSG_BUF_BYTES)
               begin
                  buf_mem[wr_ptr][widx] <= byte_nx;
                  widx                  <= widx + 8'h01;
               end
            end
            if (d_bit)
            begin
               ones <= (ones == 3'h7) ? ones : ones + 3'h1;
            end
            else
            begin
               ones <= 3'h0;
            end
            if (!d_bit && ones == FLAG_ONES)
            begin
               // End flag: one outcome
               fr_state              <= FR_HUNT;                     // R18
               chan1_state_alert_irq <= 1'b1;                        // R13
               if (bitcnt[2:0] != 3'h7)
               begin
                  chan1_state_reg <= CH_ERR_ALIGN;                   // R17
               end
               else if (widx == MSG_BUF_BYTES)
               begin
                  chan1_state_reg <= CH_ERR_LONG;                    // R14
               end
               else if (crc_nx != CRC_RESIDUE)
               begin
                  chan1_state_reg <= CH_ERR_CRC;                     // R15
               end
               else
               begin
                  chan1_state_reg  <= CH_IDLE;                       // R27
                  buf_full[wr_ptr] <= 1'b1;                          // R19
                  buf_len[wr_ptr]  <= widx + 8'h01;
                  wr_ptr           <= ~wr_ptr;
               end
            end
            else if (bitcnt[2:0] == 3'h7 && widx == MSG_BUF_BYTES
                     && (d_bit || ones != STUFF_ONES))
            begin
               // No end flag before buffer full
               fr_state              <= FR_HUNT;                     // R14
               chan1_state_reg       <= CH_ERR_LONG;                 // R18
               chan1_state_alert_irq <= 1'b1;
            end
         end
      end
   end

   // Queue 0 channel, 1 DSC
   logic       q_push [2];
   logic [7:0] q_din  [2];
   logic       q_pop  [2];
   logic       q_clr  [2];
   logic [5:0] q_cnt  [2];
   logic [7:0] q_head [2];

   // Message drain
   logic       drain_act;
   logic [7:0] drain_idx;
   logic       ready_go;
   logic       chan_push_ok;

   assign chan_push_ok = q_cnt[0] != Q_FULL;
   // Previous message must leave queue first
   assign ready_go   = ctl_burst_reg && !drain_act && buf_full[rd_ptr]
                       && (q_cnt[0] == 6'h00) && !state_rst;         // R21
   assign drain_done = drain_act && chan_push_ok
                       && (drain_idx == buf_len[rd_ptr] - 8'h01);

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         chan1_slot_stamp   <= 16'h0000;
         chan1_sample_stamp <= 16'h0000;
         chan1_msg_length   <= 16'h0000;
         chan1_freq_offset  <= 16'h0000;
         chan1_signal_level <= 16'h0000;
      end
      else if (hdr_hit && !ctl_burst_reg)
      begin
         chan1_slot_stamp   <= slot_count;                           // R6
         chan1_sample_stamp <= sample_count;
      end
      else if (ready_go)
      begin
         chan1_slot_stamp   <= stash_slot[rd_ptr];                   // R20
         chan1_sample_stamp <= stash_smp[rd_ptr];
         chan1_msg_length   <= {8'h00, buf_len[rd_ptr]};
         chan1_freq_offset  <= stash_freq[rd_ptr];
         chan1_signal_level <= stash_rssi[rd_ptr];
      end
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst || state_rst)
      begin
         drain_act           <= 1'b0;
         drain_idx           <= 8'h00;
         rd_ptr              <= 1'b0;
         chan1_msg_ready_irq <= 1'b0;
      end
      else
      begin
         chan1_msg_ready_irq <= ready_go;                            // R20
         if (ready_go)
         begin
            drain_act <= 1'b1;
            drain_idx <= 8'h00;
         end
         else if (drain_done)
         begin
            drain_act <= 1'b0;
            rd_ptr    <= ~rd_ptr;
         end
         else if (drain_act && chan_push_ok)
         begin
            drain_idx <= drain_idx + 8'h01;
         end
      end
   end

   // External DSC packing, LSB first
   logic [7:0] ext_sr;
   logic [2:0] ext_cnt;
   logic       ext_ok;

   assign ext_ok = link_en_reg && ext_bit_valid && !ext_squelch
                   && ext_carrier_detect;                            // R25

   always_ff @(posedge clk)
   begin
      if (sys_rst || !link_en_reg)
      begin
         ext_sr  <= 8'h00;
         ext_cnt <= 3'h0;
      end
      else if (ext_ok)
      begin
         ext_sr  <= {ext_serial_in, ext_sr[7:1]};                    // R2
         ext_cnt <= ext_cnt + 3'h1;
      end
   end

   // Queue feeds
   always_comb
   begin
      q_push[0] = raw_emit || raw_byte || (drain_act && chan_push_ok);
      q_din[0]  = drain_act ? buf_mem[rd_ptr][drain_idx]
                : raw_emit ? emit_sr[31:24]                          // R4
                : raw_sr_nx[7:0];                                    // R8
      q_pop[0]  = chan1_byte_queue_pop;
      q_clr[0]  = chan_clr;
      if (link_en_reg)
      begin
         q_push[1] = ext_ok && (ext_cnt == 3'h7);
         q_din[1]  = {ext_serial_in, ext_sr[7:1]};
      end
      else
      begin
         q_push[1] = (ctl_mode_reg == RX_MODE_DSC) && dsc_main_valid; // R3
         q_din[1]  = dsc_main_byte;
      end
      q_pop[1]  = dsc_byte_queue_pop;
      q_clr[1]  = dsc_clr;                                           // R1
   end

   for (genvar q = 0; q < 2; q++)
   begin : g_queue
      logic [7:0]    mem [QUEUE_DEPTH];
      logic [PW-1:0] wp;
      logic [PW-1:0] rp;
      logic          push_ok;
      logic          pop_ok;

      // Full queue drops raw/DSC bytes; drain waits
      assign push_ok = q_push[q] && (q_cnt[q] != Q_FULL);
      assign pop_ok  = q_pop[q] && (q_cnt[q] != 6'h00);

      always_ff @(posedge clk)
      begin
         if (push_ok)
         begin
            mem[wp] <= q_din[q];
         end
      end

      always_ff @(posedge clk)
      begin
         if (sys_rst || q_clr[q])
         begin
            wp        <= '0;
            rp        <= '0;
            q_cnt[q]  <= 6'h00;                                      // R1
            q_head[q] <= 8'h00;
         end
         else
         begin
            if (push_ok)
            begin
               wp <= wp + 1'b1;
            end
            if (pop_ok)
            begin
               rp <= rp + 1'b1;
            end
            q_cnt[q]  <= q_cnt[q] + {5'h00, push_ok} - {5'h00, pop_ok};
            q_head[q] <= mem[rp];
         end
      end
   end

   assign chan1_byte_queue_head = q_head[0];
   assign chan1_byte_queue_fill = q_cnt[0];
   assign dsc_byte_queue_head   = q_head[1];
   assign dsc_byte_queue_fill   = q_cnt[1];

endmodule : arx_rx_framer

`default_nettype wire

/* design/arx_pkg.sv */
// Constants and types shared by the receive framer and DSC queue control
package arx_pkg;

   // Register addresses on the control bus
   localparam logic [7:0] REG_CHAN1_CTRL       = 8'h36;
   localparam logic [7:0] REG_DSC_LINK_CONTROL = 8'h53;

   // Field positions and values after reset
   localparam int         CTRL_STATE_RST_BIT = 0;
   localparam int         CTRL_FIFO_CLR_BIT  = 1;
   localparam int         CTRL_MODE_LSB      = 2;
   localparam int         CTRL_BURST_BIT     = 4;
   localparam int         LINK_ENABLE_BIT    = 0;
   localparam int         LINK_CLEAR_BIT     = 1;
   localparam logic [1:0] RX_MODE_DSC        = 2'h2;
   localparam logic [1:0] RESET_RX_MODE      = 2'h0;

   // Channel state field encodings
   typedef logic [2:0] arx_chstate_type;
   localparam arx_chstate_type CH_IDLE        = 3'h0;
   localparam arx_chstate_type CH_RECEIVING   = 3'h1;
   localparam arx_chstate_type CH_ERR_LONG    = 3'h2;
   localparam arx_chstate_type CH_ERR_CRC     = 3'h3;
   localparam arx_chstate_type CH_ERR_OVERRUN = 3'h4;
   localparam arx_chstate_type CH_ERR_ALIGN   = 3'h5;

   // Framing constants
   localparam logic [7:0]  HDLC_FLAG     = 8'h7E;
   localparam logic [15:0] TRAIN_PAT_A   = 16'h5555;
   localparam logic [15:0] TRAIN_PAT_B   = 16'hAAAA;
   localparam logic [15:0] CRC_INIT      = 16'hFFFF;
   localparam logic [15:0] CRC_POLY      = 16'h8408;
   localparam logic [15:0] CRC_RESIDUE   = 16'hF0B8;
   localparam logic [2:0]  STUFF_ONES    = 3'h5;
   localparam logic [2:0]  FLAG_ONES     = 3'h6;
   localparam logic [7:0]  MSG_BUF_BYTES = 8'hAC;
   localparam logic [7:0]  HDR_BYTES     = 8'h04;

   // Timing
   localparam int CLK_HZ        = 20_000_000;
   localparam int SETTLE_US     = 250;
   localparam int SETTLE_CYCLES = SETTLE_US * (CLK_HZ / 1_000_000);

   typedef enum logic [1:0] {
      FR_HUNT  = 2'b01,
      FR_FRAME = 2'b10
   } arx_frame_type;

   // Byte reversal, earliest bit to bit 0
   function automatic logic [7:0] arx_rev8(input logic [7:0] v);
      logic [7:0] r;
      for (int i = 0; i < 8; i++)
      begin
         r[i] = v[7 - i];
      end
      return r;
   endfunction : arx_rev8

endpackage : arx_pkg

/* dv/arx_rx_framer_properties.sv */
// Port checks for the receive framer
`timescale 1ns/100ps
`default_nettype none
module arx_rx_framer_properties
   import arx_pkg::*;
(
   // Clock, reset, writes
   input wire logic                    clk,
   input wire logic                    sys_rst,
   input wire logic                    reg_wr,
   input wire logic [7:0]              reg_addr,
   input wire logic [7:0]              reg_wdata,
   // DSC side
   input wire logic                    dsc_main_valid,
   input wire logic                    ext_squelch,
   input wire logic [5:0]              dsc_byte_queue_fill,
   // Channel side
   input wire logic [5:0]              chan1_byte_queue_fill,
   input wire arx_pkg::arx_chstate_type chan1_state_reg,
   input wire logic [15:0]             chan1_msg_length,
   input wire logic                    chan1_state_alert_irq,
   input wire logic                    chan1_msg_ready_irq,
   input wire logic                    chan1_settling
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   a_link_clear_fill:
      assert property (reg_wr && reg_addr == REG_DSC_LINK_CONTROL && reg_wdata[1]
         |=> dsc_byte_queue_fill == 6'h00) else $error("queue not cleared");
   a_reset_idle_settle:
      assert property (reg_wr && reg_addr == REG_CHAN1_CTRL && reg_wdata[0]
         |=> (chan1_state_reg == CH_IDLE && chan1_settling) [*8]) else $error("bad reset");
   a_alert_leaves_rx:
      assert property ($rose(chan1_state_alert_irq) |-> chan1_state_reg != CH_RECEIVING
         ##1 !chan1_state_alert_irq) else $error("bad alert");
   a_error_alerts:
      assert property (chan1_state_reg >= CH_ERR_LONG && $changed(chan1_state_reg)
         |-> chan1_state_alert_irq) else $error("error without alert");
   a_ready_after_drain:
      assert property (chan1_msg_ready_irq |-> $past(chan1_byte_queue_fill) == 6'h00)
         else $error("ready before drain");
   a_ready_length:
      assert property (chan1_msg_ready_irq |-> chan1_msg_length inside {[16'h0007:16'h00AC]})
         else $error("bad length");
   a_state_codes:
      assert property (chan1_state_reg <= CH_ERR_ALIGN) else $error("bad state code");
   a_squelch_hold:
      assert property ((ext_squelch && !dsc_main_valid) [*8]
         |-> dsc_byte_queue_fill <= $past(dsc_byte_queue_fill)) else $error("queued muted");
endmodule : arx_rx_framer_properties
bind arx_rx_framer arx_rx_framer_properties u_props (.*);
`default_nettype wire

/* dv/arx_host_model.sv */
// Host that drains the channel queue
`timescale 1ns/100ps
`default_nettype none
module arx_host_model (
   // Clock, reset, enable
   input wire logic        clk,
   input wire logic        sys_rst,
   input wire logic        drain_en,
   // Queue
   input wire logic [5:0]  fill,
   input wire logic [7:0]  head,
   output var logic        pop,
   // Results
   output var logic [7:0]  first_byte,
   output var logic [15:0] got_count
);
   logic [5:0] fill_reg;
   logic       pop_reg;
   // Head lags pops and fill, so pops are paced three apart
   always_ff @(posedge clk)
   begin
      fill_reg <= fill;
      pop_reg  <= pop;
      pop      <= !sys_rst && drain_en && fill != 6'h00 && fill_reg != 6'h00 && !pop && !pop_reg;
      if (sys_rst)
         got_count <= 16'h0000;
      else if (pop)
         got_count <= got_count + 16'h0001;
      if (pop && got_count == 16'h0000)
         first_byte <= head;
   end
endmodule : arx_host_model
`default_nettype wire

/* dv/arx_rx_framer_test.sv */
// Directed bench for the receive framer
`timescale 1ns/100ps
`default_nettype none
module arx_rx_framer_test;
   import arx_pkg::*;
   logic clk = 1'b0;
   logic sys_rst, reg_wr, demod_bit, demod_bit_valid, chan1_sleep, dsc_main_valid, hen, lv, stf;
   logic ext_serial_in, ext_bit_valid, ext_carrier_detect, ext_squelch, dsc_byte_queue_pop;
   logic chan1_byte_queue_pop, chan1_state_alert_irq, chan1_msg_ready_irq, chan1_settling;
   logic [7:0] reg_addr, reg_wdata, dsc_main_byte, chan1_byte_queue_head, dsc_byte_queue_head;
   logic [7:0] first_byte;
   logic [5:0] chan1_byte_queue_fill, dsc_byte_queue_fill;
   logic [15:0] slot_count, sample_count, freq_err_in, rssi_in, chan1_slot_stamp, c, crc;
   logic [15:0] chan1_sample_stamp, chan1_msg_length, chan1_freq_offset, chan1_signal_level;
   logic [15:0] got_count;
   arx_chstate_type chan1_state_reg, al_st;
   int err_total = 0, samples_checked = 0, ones, n;
   arx_rx_framer #(.SETTLE_CNT(20)) uut (.*);
   arx_host_model hst (.clk, .sys_rst, .drain_en(hen), .fill(chan1_byte_queue_fill),
      .head(chan1_byte_queue_head), .pop(chan1_byte_queue_pop), .first_byte, .got_count);
   initial forever #25 clk = ~clk;
   always @(posedge clk) if (chan1_state_alert_irq === 1'b1) al_st <= chan1_state_reg;
   task chk(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         err_total++;
         $display("wrong value at %0t: %h not %h", $time, seen, exp);
      end
   endtask : chk
   task final_report;
      $display("%0d checks, %0d wrong", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : final_report
   task wr(input logic [7:0] a, input logic [7:0] d);
      {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
      @(posedge clk);
      reg_wr <= 1'b0;
      @(posedge clk);
   endtask : wr
   task until_low;
      for (n = 0; n < 400 && chan1_settling !== 1'b0; n++) @(posedge clk);
      if (n >= 400)
      begin
         err_total++;
         final_report();
      end
   endtask : until_low
   task rbit(input logic b, input logic ext);
      {demod_bit, ext_serial_in, demod_bit_valid, ext_bit_valid} <= {b, b, !ext, ext};
      @(posedge clk);
      {demod_bit_valid, ext_bit_valid} <= 2'b00;
      repeat (7) @(posedge clk);
   endtask : rbit
   task dbit(input logic d);
      if (stf) crc = (crc >> 1) ^ ((crc[0] ^ d) ? CRC_POLY : 16'h0000);
      lv = d ? lv : ~lv;
      rbit(lv, 1'b0);
      ones = d ? ones + 1 : 0;
      if (stf && ones == 5)
      begin
         ones = 0;
         lv = ~lv;
         rbit(lv, 1'b0);
      end
   endtask : dbit
   task dbyte(input logic [7:0] b, input logic ext);
      for (int i = 0; i < 8; i++)
         if (ext) rbit(b[i], 1'b1); else dbit(b[i]);
   endtask : dbyte
   task frame(input logic open);
      stf = 1'b0;
      if (open) repeat (3) dbyte(8'hAA, 1'b0);
      dbyte(HDLC_FLAG, 1'b0);
      {stf, ones, crc} = {open, 32'd0, CRC_INIT};
   endtask : frame
   initial
   begin
      {reg_wr, demod_bit_valid, chan1_sleep, dsc_main_valid, ext_bit_valid, hen} <= '0;
      {ext_squelch, dsc_byte_queue_pop, demod_bit, ext_serial_in, lv} <= '0;
      {ext_carrier_detect, dsc_main_byte, slot_count, sample_count} <= {1'b1, 8'h5A, 32'h12340567};
      {freq_err_in, rssi_in, sys_rst} <= {32'hFFF20070, 1'b1};
      repeat (5) @(posedge clk);
      sys_rst <= 1'b0;
      wr(REG_CHAN1_CTRL, 8'h01);
      until_low();
      chk(chan1_state_reg, CH_IDLE);
      repeat (3) dbyte(8'hAA, 1'b0);
      frame(1'b0);
      chk(chan1_state_reg, CH_RECEIVING);
      chk(chan1_byte_queue_head, 8'hCC);
      chk(chan1_slot_stamp, 16'h1234);
      repeat (8) rbit(1'b0, 1'b0);
      chk(chan1_byte_queue_fill, 6'h05);
      chan1_sleep <= 1'b1;
      repeat (8) rbit(1'b1, 1'b0);
      chan1_sleep <= 1'b0;
      chk(chan1_byte_queue_fill, 6'h05);
      $display("raw mode test done");
      wr(REG_CHAN1_CTRL, 8'h11);
      until_low();
      wr(REG_CHAN1_CTRL, 8'h12);
      hen <= 1'b1;
      frame(1'b1);
      chk(chan1_state_reg, CH_RECEIVING);
      repeat (3) dbyte(8'h00, 1'b0);
      frame(1'b0);
      chk(al_st, CH_ERR_CRC);
      frame(1'b1);
      repeat (20) dbit(1'b0);
      frame(1'b0);
      chk(al_st, CH_ERR_ALIGN);
      frame(1'b1);
      dbyte(8'h3C, 1'b0);
      c = ~crc;
      dbyte(c[7:0], 1'b0);
      dbyte(c[15:8], 1'b0);
      frame(1'b0);
      chk(al_st, CH_IDLE);
      for (n = 0; n < 400 && got_count !== 16'h0008; n++) @(posedge clk);
      chk(chan1_msg_length, 16'h0008);
      chk(chan1_freq_offset, 16'hFFF2);
      chk(first_byte, 8'hAA);
      $display("burst mode test done");
      wr(REG_DSC_LINK_CONTROL, 8'h01);
      dsc_main_valid <= 1'b1;
      dbyte(8'hB4, 1'b1);
      chk(dsc_byte_queue_head, 8'hB4);
      {dsc_main_valid, ext_squelch} <= 2'b01;
      dbyte(8'h0F, 1'b1);
      chk(dsc_byte_queue_fill, 6'h01);
      wr(REG_DSC_LINK_CONTROL, 8'h02);
      chk(dsc_byte_queue_fill, 6'h00);
      wr(REG_CHAN1_CTRL, 8'h08);
      dbyte(8'h01, 1'b1);
      dsc_main_valid <= 1'b1;
      repeat (4) @(posedge clk);
      dsc_main_valid <= 1'b0;
      wr(8'h54, 8'h02);
      chk(dsc_byte_queue_head, 8'h5A);
      $display("DSC queue test done");
      final_report();
   end
endmodule : arx_rx_framer_test
`default_nettype wire
